//--- core/spmh_defs.svh
// constants for the serial port modem handshake block
`ifndef SPMH_DEFS_SVH
`define SPMH_DEFS_SVH
// host i/o register offsets within the selected window
`define SPMH_OFF_IER_A 3'h1
`define SPMH_OFF_MCR_A 3'h4
`define SPMH_OFF_MSR_A 3'h6
`define SPMH_PORT_B_BIT 3
// modem control bit positions
`define SPMH_MCR_DTR 0
`define SPMH_MCR_RTS 1
`define SPMH_MCR_LOOP 4
// interrupt enable bit position
`define SPMH_IER_EMSI 3
// reset values
`define SPMH_MCR_RST 8'h00
`define SPMH_IER_RST 8'h00
// timing
`define SPMH_CLK_NS 20
`define SPMH_RESET_MIN_NS 500
`define SPMH_RESET_MIN_CYC ((`SPMH_RESET_MIN_NS + `SPMH_CLK_NS - 1) / `SPMH_CLK_NS)
`define SPMH_FIFO_DEPTH 4
`endif

//--- core/spmh_pkg.sv
// types for the serial port modem handshake block
package spmh_pkg;
    typedef enum logic [1:0] {
        SPMH_BUS_IDLE = 2'b00,
        SPMH_BUS_READ = 2'b01,
        SPMH_BUS_WRITE = 2'b10
    } spmh_bus_state_type;
    typedef logic [7:0] spmh_byte_type;
endpackage

//--- core/spmh_fifo.sv
// small parameterised fifo for host register read data
`timescale 1ns/1ns
module spmh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH]; // storage words
    logic [AW-1:0] wr_ptr_reg; // next write slot
    logic [AW-1:0] rd_ptr_reg; // next read slot
    logic [AW:0] count_reg; // words held
    logic push;
    logic pop;

    // honest full and empty
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointers wrap at depth
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule

//--- core/spmh_top.sv
// modem handshake logic of two serial ports with host i/o access
//
// What this block does
// - send-request pin follows its control bit, inverted
// - terminal-ready pin follows its control bit, inverted
// - handshake outputs inactive on reset and loopback
// - clear-to-send rise sets its delta flag
// - set-ready rise sets its delta flag
// - carrier-detect rise sets its change flag
// - ring rise sets its edge flag
// - enabled modem interrupt on any input change
// - live status bits are inverted input pins
// - address captured at strobe leading edge
// - data lines driven only during reads
// - address enable qualifies decode, blocks dma
// - reset spares configuration, clears operating state
// - access accepted only while chip select active
// - one clock times all internal logic
//
// reads are queued on the taking edge
// and driven from the next edge on
// writes land on the taking edge and
// reach the pins one edge later
//
// config survives system reset; it is
// seeded only at power-up, so software
// must program it after power-on
`timescale 1ns/1ns
`include "spmh_defs.svh"
module spmh_top #(
    // address lines seen by the decoder
    parameter int ADDR_W = 11,
    // read queue depth
    parameter int FIFO_DEPTH = `SPMH_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host i/o bus
    input wire logic [ADDR_W-1:0] host_io_address,
    input wire logic [7:0] host_io_data_in,
    output spmh_pkg::spmh_byte_type host_io_data_out,
    output logic host_io_data_oe_n,
    input wire logic host_addr_qualify,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic chip_select_n,
    // port a modem lines
    output logic send_request_out_n_a,
    output logic terminal_ready_out_n_a,
    input wire logic clear_send_in_n_a,
    input wire logic set_ready_in_n_a,
    input wire logic carrier_in_n_a,
    input wire logic ring_in_n_a,
    // port b modem lines
    output logic send_request_out_n_b,
    output logic terminal_ready_out_n_b,
    input wire logic clear_send_in_n_b,
    input wire logic set_ready_in_n_b,
    input wire logic carrier_in_n_b,
    input wire logic ring_in_n_b,
    // interrupt requests, one per port
    output logic modem_irq_a,
    output logic modem_irq_b
);
    import spmh_pkg::*;

    // host access tracking
    spmh_bus_state_type bus_state_reg; // host access phase
    logic [ADDR_W-1:0] addr_reg; // captured address
    logic sel_ok; // qualified selection
    logic rd_lead; // read leading edge
    logic wr_lead; // write leading edge
    logic [2:0] reg_off; // offset in window
    logic port_sel; // 0 = port a, 1 = port b
    logic [2:0] cap_off; // offset of captured address
    logic cap_port; // port of captured address

    // configuration, index 0 is port a
    logic [7:0] modem_control_register [2]; // configuration, kept over reset
    logic [7:0] interrupt_enable_register [2]; // configuration, kept over reset

    // modem input state
    logic [3:0] pin_n [2]; // inputs: ring, carrier, set-ready, clear-send
    logic [3:0] pin_prev_reg [2]; // last sampled pins
    logic [3:0] delta_reg [2]; // latched change flags

    // interrupt and read paths
    logic [1:0] irq_reg; // pending interrupt per port
    logic [1:0] msr_read; // status read pulse per port
    logic [7:0] msr_value [2]; // status byte per port
    logic [7:0] rd_byte; // byte selected for read

    // power-up seed and read queue
    logic cfg_init_reg = 1'b0; // low only before the first clock
    logic fifo_in_ready; // unread
    logic fifo_out_valid; // a byte waits
    logic [7:0] fifo_out_data; // queue head

    // each port as {ring, carrier, set-ready, clear-send}
    assign pin_n[0] = {ring_in_n_a, carrier_in_n_a, set_ready_in_n_a, clear_send_in_n_a};
    assign pin_n[1] = {ring_in_n_b, carrier_in_n_b, set_ready_in_n_b, clear_send_in_n_b};

    // decode only a real, selected, non-dma cycle
    // a high qualifier marks dma
    assign sel_ok = !chip_select_n && !host_addr_qualify;
    assign rd_lead = sel_ok && !host_read_strobe_n && bus_state_reg == SPMH_BUS_IDLE;
    // read wins when both strobes are low
    assign wr_lead = sel_ok && !host_write_strobe_n && bus_state_reg == SPMH_BUS_IDLE
        && host_read_strobe_n;
    // offset in window; bit 3 picks the port
    assign reg_off = {1'b0, host_io_address[1:0]} | {host_io_address[2], 2'b00};
    assign port_sel = host_io_address[`SPMH_PORT_B_BIT];
    // fields of the captured address
    assign cap_off = addr_reg[2:0];
    assign cap_port = addr_reg[`SPMH_PORT_B_BIT];

    // access phase follows the strobes; one action per strobe
    // a strobe held low must not act twice
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // reset abandons any access
            bus_state_reg <= SPMH_BUS_IDLE;
        end else begin
            unique case (bus_state_reg)
                SPMH_BUS_IDLE: begin
                    // wait for a taking edge
                    if (rd_lead) begin
                        bus_state_reg <= SPMH_BUS_READ;
                    end else if (wr_lead) begin
                        bus_state_reg <= SPMH_BUS_WRITE;
                    end
                end
                SPMH_BUS_READ: begin
                    // hold until the strobe ends
                    if (host_read_strobe_n) begin
                        bus_state_reg <= SPMH_BUS_IDLE;
                    end
                end
                SPMH_BUS_WRITE: begin
                    // hold until the strobe ends
                    if (host_write_strobe_n) begin
                        bus_state_reg <= SPMH_BUS_IDLE;
                    end
                end
                default: begin
                    // illegal code, back to idle
                    bus_state_reg <= SPMH_BUS_IDLE;
                end
            endcase
        end
    end

    // address held from leading edge for the whole access
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // operating state, cleared
            addr_reg <= '0;
        end else if (rd_lead || wr_lead) begin
            // later address moves are ignored
            addr_reg <= host_io_address;
        end
    end

    // configuration is seeded once, then never touched by reset
    // no reset here: a system reset must not reseed
    always_ff @(posedge clk) begin
        if (!cfg_init_reg) begin
            // stays high from then on
            cfg_init_reg <= 1'b1;
        end
    end

    // control and enable registers; system reset leaves them alone
    always_ff @(posedge clk) begin
        if (!cfg_init_reg) begin
            // power-up seed only
            for (int p = 0; p < 2; p++) begin
                modem_control_register[p] <= `SPMH_MCR_RST;
                interrupt_enable_register[p] <= `SPMH_IER_RST;
            end
        end else if (wr_lead) begin
            // writes land on the taking edge
            // port_sel picks the register pair
            if (reg_off == `SPMH_OFF_MCR_A) begin
                modem_control_register[port_sel] <= host_io_data_in;
            end
            if (reg_off == `SPMH_OFF_IER_A) begin
                interrupt_enable_register[port_sel] <= host_io_data_in;
            end
        end
    end

    // status reads are one-cycle pulses at the read leading edge
    // a change in the clearing cycle survives,
    // so no edge is lost
    always_comb begin
        msr_read = 2'b00;
        if (rd_lead && reg_off == `SPMH_OFF_MSR_A) begin
            msr_read[port_sel] = 1'b1;
        end
    end

    // change detection: pins sampled each clock
    // inputs are already synchronous to clk
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // idle level, so no false edge after reset
            for (int p = 0; p < 2; p++) begin
                pin_prev_reg[p] <= 4'hf;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                pin_prev_reg[p] <= pin_n[p];
            end
        end
    end

    // change flags: rising pin sets, status read clears, set wins
    // only a low-to-high move sets a flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // flags are operating state
            for (int p = 0; p < 2; p++) begin
                delta_reg[p] <= 4'h0;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                // both ports alike
                delta_reg[p] <= (msr_read[p] ? 4'h0 : delta_reg[p])
                    | (pin_n[p] & ~pin_prev_reg[p]);
            end
        end
    end

    // interrupt: any change in either direction while enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // operating state, cleared
            irq_reg <= 2'b00;
        end else begin
            // each port on its own
            for (int p = 0; p < 2; p++) begin
                if (!interrupt_enable_register[p][`SPMH_IER_EMSI]) begin
                    // disable drops a pending request
                    irq_reg[p] <= 1'b0;
                end else if (pin_n[p] != pin_prev_reg[p]) begin
                    // a change wins over a read
                    irq_reg[p] <= 1'b1;
                end else if (msr_read[p]) begin
                    // a status read clears
                    irq_reg[p] <= 1'b0;
                end
            end
        end
    end
    assign modem_irq_a = irq_reg[0];
    assign modem_irq_b = irq_reg[1];

    // status byte: live bits complement of pins, deltas low
    // order: carrier, ring, set-ready, clear-send
    // in both nibbles
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            msr_value[p] = {~pin_n[p][2], ~pin_n[p][3], ~pin_n[p][1], ~pin_n[p][0],
                delta_reg[p][2], delta_reg[p][3], delta_reg[p][1], delta_reg[p][0]};
        end
    end

    // read mux; unmapped offsets read as zero
    // live address, as sampled at the taking edge
    always_comb begin
        unique case (reg_off)
            `SPMH_OFF_MCR_A: rd_byte = modem_control_register[port_sel];
            `SPMH_OFF_IER_A: rd_byte = interrupt_enable_register[port_sel];
            `SPMH_OFF_MSR_A: rd_byte = msr_value[port_sel];
            // unused offsets never float
            default: rd_byte = 8'h00;
        endcase
    end

    // read data queued; the queue drains as each read strobe ends,
    // so the queue never holds more than one byte
    // push on the taking edge, pop as the strobe ends
    // in_ready unread: one push per strobe
    spmh_fifo #(
        // byte wide
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_read_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(rd_lead),
        .in_ready(fifo_in_ready),
        .in_data(rd_byte),
        .out_valid(fifo_out_valid),
        .out_ready(bus_state_reg == SPMH_BUS_READ && host_read_strobe_n),
        .out_data(fifo_out_data)
    );

    // data output register, driven only in a read phase
    // released one clock after the strobe ends
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // bus released
            host_io_data_out <= 8'h00;
            host_io_data_oe_n <= 1'b1;
        end else begin
            // data follows the queue head
            host_io_data_out <= fifo_out_data;
            // drivers open only for a selected read
            host_io_data_oe_n <= !(bus_state_reg == SPMH_BUS_READ && fifo_out_valid
                && !host_read_strobe_n && sel_ok);
        end
    end

    // handshake outputs: inverted control bits, forced inactive
    // registered, so pins never glitch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // all four inactive
            send_request_out_n_a <= 1'b1;
            terminal_ready_out_n_a <= 1'b1;
            send_request_out_n_b <= 1'b1;
            terminal_ready_out_n_b <= 1'b1;
        end else begin
            // loopback forces both pins inactive
            // port a
            send_request_out_n_a <= !modem_control_register[0][`SPMH_MCR_RTS]
                || modem_control_register[0][`SPMH_MCR_LOOP];
            terminal_ready_out_n_a <= !modem_control_register[0][`SPMH_MCR_DTR]
                || modem_control_register[0][`SPMH_MCR_LOOP];
            // port b
            send_request_out_n_b <= !modem_control_register[1][`SPMH_MCR_RTS]
                || modem_control_register[1][`SPMH_MCR_LOOP];
            terminal_ready_out_n_b <= !modem_control_register[1][`SPMH_MCR_DTR]
                || modem_control_register[1][`SPMH_MCR_LOOP];
        end
    end
endmodule

//--- test/spmh_modem.sv
// behavioural modem driving the handshake inputs of both ports
`timescale 1ns/1ns
module spmh_modem (
    // clock
    input wire logic clk,
    // commanded levels, {carrier, ring, set_ready, clear_send}
    input wire logic [3:0] want_n_a,
    input wire logic [3:0] want_n_b,
    // handshake lines into the block, idle means inactive high
    output logic [3:0] line_n_a = 4'hf,
    output logic [3:0] line_n_b = 4'hf
);
    // lines move only just after an edge, like a modem's own clocked logic
    always @(posedge clk) begin
        line_n_a <= want_n_a;
        line_n_b <= want_n_b;
    end
endmodule

//--- test/spmh_top_sva.sv
// checker for the host bus and handshake pins of the modem block
`timescale 1ns/1ns
module spmh_top_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host bus
    input wire logic host_io_data_oe_n,
    input wire logic host_addr_qualify,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic chip_select_n,
    // modem lines
    input wire logic send_request_out_n_a,
    input wire logic terminal_ready_out_n_a,
    input wire logic send_request_out_n_b,
    input wire logic terminal_ready_out_n_b,
    input wire logic clear_send_in_n_a,
    input wire logic set_ready_in_n_a,
    input wire logic carrier_in_n_a,
    input wire logic ring_in_n_a,
    input wire logic clear_send_in_n_b,
    input wire logic set_ready_in_n_b,
    input wire logic carrier_in_n_b,
    input wire logic ring_in_n_b,
    // interrupts
    input wire logic modem_irq_a,
    input wire logic modem_irq_b
);
    wire [3:0] outs = {send_request_out_n_b, terminal_ready_out_n_b,
        send_request_out_n_a, terminal_ready_out_n_a};
    wire [3:0] pins_a = {carrier_in_n_a, ring_in_n_a, set_ready_in_n_a, clear_send_in_n_a};
    wire [3:0] pins_b = {carrier_in_n_b, ring_in_n_b, set_ready_in_n_b, clear_send_in_n_b};
    logic [3:0] pins_a_reg, pins_b_reg; // pin levels one edge ago
    logic [3:0] quiet_a_reg, quiet_b_reg; // edges since a pin moved, saturating
    // remember pins to spot a change
    always_ff @(posedge clk) begin
        pins_a_reg <= pins_a;
        pins_b_reg <= pins_b;
    end
    // age of the last change; reset parks it at the far end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            quiet_a_reg <= 4'hf;
            quiet_b_reg <= 4'hf;
        end else begin
            quiet_a_reg <= (pins_a != pins_a_reg) ? 4'h0
                : quiet_a_reg + {3'h0, quiet_a_reg != 4'hf};
            quiet_b_reg <= (pins_b != pins_b_reg) ? 4'h0
                : quiet_b_reg + {3'h0, quiet_b_reg != 4'hf};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // strobes idle long enough for any clear to have landed
    sequence bus_quiet;
        (host_read_strobe_n && host_write_strobe_n)[*5];
    endsequence
    sequence unselected;
        (host_addr_qualify || chip_select_n)[*3];
    endsequence
    read_source_a: assert property ($fell(host_io_data_oe_n) |->
        $past(!host_read_strobe_n && !chip_select_n && !host_addr_qualify))
        else $error("data bus driven without a selected read");
    read_release_a: assert property ($rose(host_read_strobe_n) |-> ##[1:2] host_io_data_oe_n)
        else $error("data bus still driven after read ended");
    reset_idle_a: assert property ($rose(rst_n) |-> outs == 4'hf
        && host_io_data_oe_n && !modem_irq_a && !modem_irq_b)
        else $error("outputs not idle after reset");
    pins_cause_a: assert property ($changed(outs) && $past(rst_n) && $past(rst_n, 2)
        && $past(rst_n, 3) |-> $past(!host_write_strobe_n && !chip_select_n
        && !host_addr_qualify, 2)) else $error("handshake pins moved without a write");
    irq_cause_a: assert property ($rose(modem_irq_a) |-> quiet_a_reg <= 4'h7)
        else $error("port a interrupt without a pin change");
    irq_cause_b_a: assert property ($rose(modem_irq_b) |-> quiet_b_reg <= 4'h7)
        else $error("port b interrupt without a pin change");
    irq_hold_a: assert property (bus_quiet ##0 modem_irq_a |=> modem_irq_a)
        else $error("port a interrupt dropped without access");
    dma_refuse_a: assert property (unselected |-> host_io_data_oe_n)
        else $error("data bus driven while not selected");
endmodule
bind spmh_top spmh_top_sva checker_i (.clk(clk), .rst_n(rst_n),
    .host_io_data_oe_n(host_io_data_oe_n), .host_addr_qualify(host_addr_qualify),
    .host_read_strobe_n(host_read_strobe_n), .host_write_strobe_n(host_write_strobe_n),
    .chip_select_n(chip_select_n), .send_request_out_n_a(send_request_out_n_a),
    .terminal_ready_out_n_a(terminal_ready_out_n_a), .send_request_out_n_b(send_request_out_n_b),
    .terminal_ready_out_n_b(terminal_ready_out_n_b), .clear_send_in_n_a(clear_send_in_n_a),
    .set_ready_in_n_a(set_ready_in_n_a), .carrier_in_n_a(carrier_in_n_a),
    .ring_in_n_a(ring_in_n_a), .clear_send_in_n_b(clear_send_in_n_b),
    .set_ready_in_n_b(set_ready_in_n_b), .carrier_in_n_b(carrier_in_n_b),
    .ring_in_n_b(ring_in_n_b), .modem_irq_a(modem_irq_a), .modem_irq_b(modem_irq_b));

//--- test/tb.sv
// self-checking bench for the modem handshake block
`timescale 1ns/1ns
`include "spmh_defs.svh"
module tb;
    import spmh_pkg::*;
    // clock, reset and host bus drive; bus idle and reset held low at time zero
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic aen = 1'b0;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic [10:0] addr = 11'h000;
    logic [7:0] wdata = 8'h00;
    logic [3:0] want_n_a = 4'hf; // modem commands
    logic [3:0] want_n_b = 4'hf;
    spmh_byte_type rdata;
    wire oe_n, irq_a, irq_b;
    wire [3:0] line_n_a, line_n_b;
    wire [3:0] hs_n; // {rts b, dtr b, rts a, dtr a}
    wire [3:0] irqs = {2'b00, irq_b, irq_a};
    wire [7:0] hd = oe_n ? 8'hzz : rdata; // the shared data wires
    int error_cnt = 0;
    int n_compared = 0;
    spmh_modem modem (.clk(clk), .want_n_a(want_n_a), .want_n_b(want_n_b),
        .line_n_a(line_n_a), .line_n_b(line_n_b));
    spmh_top dut (.clk(clk), .rst_n(rst_n), .host_io_address(addr), .host_io_data_in(wdata),
        .host_io_data_out(rdata), .host_io_data_oe_n(oe_n), .host_addr_qualify(aen),
        .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .chip_select_n(cs_n),
        .send_request_out_n_a(hs_n[1]), .terminal_ready_out_n_a(hs_n[0]),
        .clear_send_in_n_a(line_n_a[0]), .set_ready_in_n_a(line_n_a[1]),
        .ring_in_n_a(line_n_a[2]), .carrier_in_n_a(line_n_a[3]),
        .send_request_out_n_b(hs_n[3]), .terminal_ready_out_n_b(hs_n[2]),
        .clear_send_in_n_b(line_n_b[0]), .set_ready_in_n_b(line_n_b[1]),
        .ring_in_n_b(line_n_b[2]), .carrier_in_n_b(line_n_b[3]),
        .modem_irq_a(irq_a), .modem_irq_b(irq_b));
    // 50 mhz clock
    initial begin
        forever #10 clk = ~clk;
    end
    // every drive and look lands 2 ns after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic check4(input string what, input logic [3:0] exp, input logic [3:0] got);
        check8(what, {4'h0, exp}, {4'h0, got});
    endtask
    // one host access; f = {move address late, dma cycle, unselected}
    task automatic bus(input logic wr, input logic [3:0] sel, input logic [7:0] wd,
            input logic [2:0] f, output logic [7:0] rd);
        int k;
        k = 0;
        addr = {7'h00, sel};
        wdata = wd;
        aen = f[1];
        cs_n = f[0];
        if (wr) begin
            wr_n = 1'b0;
            tick(2);
            // address already captured, so moving it must not matter
            if (f[2]) begin
                addr = 11'h007;
            end
            tick(1);
        end else begin
            rd_n = 1'b0;
            while (oe_n !== 1'b0 && k < 8) begin
                tick(1);
                k++;
            end
        end
        rd = hd;
        wr_n = 1'b1;
        rd_n = 1'b1;
        cs_n = 1'b1;
        aen = 1'b0;
        tick(2);
    endtask
    task automatic reg_write(input logic p, input logic [2:0] off, input logic [7:0] v,
            input logic [2:0] f);
        logic [7:0] d;
        bus(1'b1, {p, off}, v, f, d);
    endtask
    task automatic reg_read(input logic p, input logic [2:0] off, input logic [7:0] exp,
            input logic [2:0] f);
        logic [7:0] d;
        bus(1'b0, {p, off}, 8'h00, f, d);
        check8("read data", exp, d);
    endtask
    task automatic set_pins(input logic p, input logic [3:0] x);
        if (p) want_n_b = x;
        else want_n_a = x;
    endtask
    // control bits drive the pins, loopback silences them
    task automatic t_control();
        for (int p = 0; p < 2; p++) begin
            for (int v = 0; v < 4; v++) begin
                reg_write(p[0], `SPMH_OFF_MCR_A, v[7:0], 3'b000);
                check4("handshake pins", p ? {~v[1:0], 2'b00} : {2'b11, ~v[1:0]}, hs_n);
            end
        end
        reg_write(1'b0, `SPMH_OFF_MCR_A, 8'h13, 3'b000);
        check4("handshake pins", 4'h3, hs_n);
        reg_write(1'b0, `SPMH_OFF_MCR_A, 8'h03, 3'b000);
    endtask
    // mid-run reset of the full host length keeps configuration
    task automatic t_reset();
        rst_n = 1'b0;
        tick(25);
        check4("handshake pins", 4'hf, hs_n);
        check4("interrupt lines", 4'h0, irqs);
        rst_n = 1'b1;
        tick(3);
        check4("handshake pins", 4'h0, hs_n);
        reg_write(1'b0, `SPMH_OFF_MCR_A, 8'h00, 3'b000);
        reg_write(1'b1, `SPMH_OFF_MCR_A, 8'h00, 3'b000);
    endtask
    // each input alone rises and sets only its own flag; reads clear
    task automatic t_flags();
        logic [7:0] d;
        logic [3:0] x;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                x = 4'h1 << i;
                set_pins(p[0], 4'h0);
                tick(6);
                bus(1'b0, {p[0], `SPMH_OFF_MSR_A}, 8'h00, 3'b000, d);
                reg_read(p[0], `SPMH_OFF_MSR_A, 8'hf0, 3'b000);
                set_pins(p[0], x);
                tick(6);
                reg_read(p[0], `SPMH_OFF_MSR_A, {~x, x}, 3'b000);
                reg_read(p[0], `SPMH_OFF_MSR_A, {~x, 4'h0}, 3'b000);
            end
            set_pins(p[0], 4'hf);
        end
    endtask
    // interrupt on change in either direction, held until read or disable
    task automatic t_irq();
        logic [7:0] d;
        for (int p = 0; p < 2; p++) begin
            reg_write(p[0], `SPMH_OFF_IER_A, 8'h08, 3'b000);
            bus(1'b0, {p[0], `SPMH_OFF_MSR_A}, 8'h00, 3'b000, d);
            check4("interrupt lines", 4'h0, irqs);
            set_pins(p[0], 4'he);
            tick(8);
            check4("interrupt lines", 4'h1 << p, irqs);
            tick(12);
            check4("interrupt lines", 4'h1 << p, irqs);
            bus(1'b0, {p[0], `SPMH_OFF_MSR_A}, 8'h00, 3'b000, d);
            check4("interrupt lines", 4'h0, irqs);
            set_pins(p[0], 4'hf);
            tick(8);
            check4("interrupt lines", 4'h1 << p, irqs);
            reg_write(p[0], `SPMH_OFF_IER_A, 8'h00, 3'b000);
            check4("interrupt lines", 4'h0, irqs);
        end
    endtask
    // dma or unselected cycles are ignored; late address moves are ignored
    task automatic t_refuse();
        reg_write(1'b0, `SPMH_OFF_MCR_A, 8'h03, 3'b010);
        reg_write(1'b0, `SPMH_OFF_MCR_A, 8'h03, 3'b001);
        check4("handshake pins", 4'hf, hs_n);
        reg_read(1'b0, `SPMH_OFF_MSR_A, 8'hzz, 3'b010);
        reg_read(1'b1, `SPMH_OFF_MSR_A, 8'hzz, 3'b001);
        reg_read(1'b0, 3'h5, 8'h00, 3'b000);
        reg_write(1'b0, `SPMH_OFF_MCR_A, 8'h03, 3'b100);
        check4("handshake pins", 4'hc, hs_n);
        reg_write(1'b0, `SPMH_OFF_MCR_A, 8'h00, 3'b000);
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // whole run is under 500 cycles; allow 60 times that
    initial begin
        #(20 * 30000);
        error_cnt++;
        print_verdict();
    end
    initial begin
        tick(5);
        rst_n = 1'b1;
        tick(1);
        t_control();
        t_reset();
        t_flags();
        t_irq();
        t_refuse();
        print_verdict();
    end
endmodule
